// ---- hw/iochh_handler.sv ----
// Channel-side I/O instruction handler with register port and unit interface
`include "iochh_consts.svh"
`default_nettype none
module iochh_handler import iochh_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire iochh_instr_t instr,
  output iochh_resp_t resp,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic [15:0] unit_present,
  output logic [3:0] unit_sel,
  output logic unit_link_up,
  output logic unit_cmd_valid,
  output logic [23:0] unit_word,
  input wire logic unit_cmd_ready,
  output logic unit_dout_valid,
  input wire logic unit_dout_ready,
  input wire logic [7:0] unit_status,
  input wire logic unit_status_valid,
  input wire logic [23:0] unit_din,
  input wire logic unit_din_valid,
  output logic unit_din_take,
  output logic unit_addr_valid,
  output logic [2:0] unit_addr_sel,
  output logic chan_drv_en,
  output logic chan_mpx_release,
  input wire logic bt_active,
  input wire logic [23:0] bt_word_count,
  output logic bt_stop
);

  // --------------------------------------------------------------------------
  // Field helpers
  // --------------------------------------------------------------------------

  // Unit code of an instruction word
  function automatic logic [3:0] unit_of(input logic [23:0] w);
    unit_of = w[`IOCHH_UNIT_HI:`IOCHH_UNIT_LO];
  endfunction : unit_of

  // Channel number of an instruction word
  function automatic logic [4:0] chan_of(input logic [23:0] w);
    chan_of = w[`IOCHH_CHAN_HI:`IOCHH_CHAN_LO];
  endfunction : chan_of

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  iochh_state_t state_q, state_d;
  logic [1:0] sw_cnt_q, sw_cnt_d;
  logic [3:0] conn_q, conn_d;
  logic [3:0] target_q, target_d;
  logic fwd_cmd_q, fwd_cmd_d;
  logic fwd_data_q, fwd_data_d;
  logic [23:0] word_q, word_d;
  iochh_mode_t mode_q, mode_d;
  logic dead_q, dead_d;
  logic [7:0] cfg_q;
  logic [23:0] xfer_addr_q, param_addr_q;
  iochh_resp_t resp_q, resp_d;
  logic bt_stop_q, bt_stop_d;
  logic din_take_q, din_take_d;
  logic addr_valid_q, addr_valid_d;
  logic [2:0] addr_sel_q, addr_sel_d;
  logic ld_xfer, ld_param;
  logic [23:0] reg_rdata_q;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire [4:0] cfg_chan = cfg_q[4:0];
  wire iochh_kind_t cfg_kind = iochh_kind_t'(cfg_q[6:5]);
  wire cfg_single = cfg_q[7];
  wire is_block = (cfg_kind == IOCHH_KIND_BLOCK);
  wire is_unit_addr = (cfg_kind == IOCHH_KIND_UNIT_X) || (cfg_kind == IOCHH_KIND_UNIT_I);
  wire [3:0] req_unit = unit_of(instr.word); // [RULE2]
  wire iochh_mode_t req_mode = iochh_mode_t'(instr.word[`IOCHH_MODE_HI:`IOCHH_MODE_LO]);
  wire req_ovr = instr.word[`IOCHH_OVR_BIT];
  wire chan_ok = (chan_of(instr.word) == cfg_chan) && !dead_q;
  wire unit_exists = unit_present[req_unit];
  wire other_unit = (req_unit != conn_q); // [RULE28]
  wire idle = (state_q == IOCHH_ST_IDLE);
  wire bt_busy = is_block && bt_active;
  wire [23:0] bt_status = {1'b1, 15'h0000, unit_status}; // [RULE10]

  // --------------------------------------------------------------------------
  // Instruction handling and sequencing
  // --------------------------------------------------------------------------

  // Next-state logic: the answer starts not-zero and is cleared only on acceptance
  always_comb begin
    state_d = state_q;
    sw_cnt_d = sw_cnt_q;
    conn_d = conn_q;
    target_d = target_q;
    fwd_cmd_d = fwd_cmd_q;
    fwd_data_d = fwd_data_q;
    word_d = word_q;
    mode_d = mode_q;
    dead_d = dead_q;
    bt_stop_d = 1'b0;
    din_take_d = 1'b0;
    addr_valid_d = 1'b0;
    addr_sel_d = addr_sel_q;
    ld_xfer = 1'b0;
    ld_param = 1'b0;
    resp_d = '0;
    resp_d.valid = instr.valid;
    resp_d.cond_not_zero = 1'b1; // [RULE24]
    resp_d.acc = resp_q.acc;

    // Unit switching and delivery to the connected unit
    case (state_q)
      IOCHH_ST_SWITCH: begin
        if (sw_cnt_q == `IOCHH_SWITCH_CYCLES - 2'h1) begin // [RULE25]
          conn_d = target_q;
          if (fwd_cmd_q) begin
            state_d = IOCHH_ST_CMD_PEND;
          end else if (fwd_data_q) begin
            state_d = IOCHH_ST_DOUT_PEND;
          end else begin
            state_d = IOCHH_ST_IDLE;
          end
          fwd_cmd_d = 1'b0;
          fwd_data_d = 1'b0;
        end else begin
          sw_cnt_d = sw_cnt_q + 2'h1;
        end
      end
      IOCHH_ST_CMD_PEND: begin
        if (unit_cmd_ready) begin
          state_d = IOCHH_ST_IDLE; // [RULE5]
        end
      end
      IOCHH_ST_DOUT_PEND: begin
        if (unit_dout_ready) begin
          state_d = IOCHH_ST_IDLE;
        end
      end
      IOCHH_ST_IDLE: begin
        state_d = IOCHH_ST_IDLE;
      end
      default: begin
        state_d = IOCHH_ST_IDLE;
      end
    endcase

    if (instr.valid && chan_ok && !unit_exists && instr.op != IOCHH_OP_ADDR_OUT) begin
      dead_d = 1'b1; // [RULE27]
    end else if (instr.valid && chan_ok) begin
      case (instr.op)
        IOCHH_OP_CMD_OUT: begin
          if (req_ovr) begin
            // Override takes the channel whatever it is doing
            word_d = instr.acc; // [RULE1] [RULE3]
            target_d = req_unit;
            sw_cnt_d = 2'h0;
            fwd_cmd_d = 1'b1;
            fwd_data_d = 1'b0;
            state_d = IOCHH_ST_SWITCH;
            resp_d.cond_not_zero = 1'b0;
            bt_stop_d = bt_busy; // [RULE6]
          end else if (!bt_busy && idle) begin // [RULE6]
            word_d = instr.acc; // [RULE1]
            if (other_unit) begin
              target_d = req_unit; // [RULE4]
              sw_cnt_d = 2'h0;
              fwd_cmd_d = 1'b1;
              state_d = IOCHH_ST_SWITCH;
            end else begin
              state_d = IOCHH_ST_CMD_PEND;
              resp_d.cond_not_zero = 1'b0; // [RULE1]
            end
          end
          if (req_ovr || (!bt_busy && idle)) begin
            if (!(req_mode == IOCHH_MODE_MPX && is_unit_addr)) begin
              mode_d = (req_mode == IOCHH_MODE_RESET) ? IOCHH_MODE_NORMAL : req_mode; // [RULE26]
            end
          end
        end
        IOCHH_OP_STAT_IN: begin
          if (bt_busy) begin
            resp_d.cond_not_zero = 1'b0; // [RULE10]
            resp_d.acc_load = 1'b1;
            resp_d.acc = bt_status;
          end else if (state_q == IOCHH_ST_CMD_PEND || state_q == IOCHH_ST_SWITCH) begin
            resp_d.cond_not_zero = 1'b1; // [RULE8]
          end else if (other_unit) begin
            if (idle) begin
              target_d = req_unit; // [RULE9]
              sw_cnt_d = 2'h0;
              state_d = IOCHH_ST_SWITCH;
            end
          end else if (unit_status_valid) begin
            resp_d.cond_not_zero = 1'b0; // [RULE7] [RULE11]
            resp_d.acc_load = 1'b1;
            resp_d.acc = {16'h0000, unit_status};
          end
        end
        IOCHH_OP_DATA_OUT: begin
          if (!bt_busy && idle) begin // [RULE15]
            word_d = instr.acc; // [RULE12]
            resp_d.cond_not_zero = 1'b0;
            if (other_unit) begin
              target_d = req_unit; // [RULE14]
              sw_cnt_d = 2'h0;
              fwd_data_d = 1'b1;
              state_d = IOCHH_ST_SWITCH;
            end else begin
              state_d = IOCHH_ST_DOUT_PEND;
            end
          end
        end
        IOCHH_OP_DATA_IN: begin
          if (bt_busy) begin
            resp_d.cond_not_zero = 1'b1; // [RULE18]
          end else if (state_q == IOCHH_ST_CMD_PEND || state_q == IOCHH_ST_SWITCH) begin
            resp_d.cond_not_zero = 1'b1; // [RULE16] [RULE19]
          end else if (is_block && cfg_single && state_q == IOCHH_ST_DOUT_PEND) begin
            resp_d.cond_not_zero = 1'b1; // [RULE19]
          end else if (other_unit) begin
            if (idle) begin
              target_d = req_unit; // [RULE17]
              sw_cnt_d = 2'h0;
              state_d = IOCHH_ST_SWITCH;
            end
          end else if (unit_din_valid) begin
            resp_d.cond_not_zero = 1'b0; // [RULE16]
            resp_d.acc_load = 1'b1;
            resp_d.acc = req_ovr ? (instr.acc | unit_din) : unit_din; // [RULE20]
            din_take_d = 1'b1;
          end
        end
        IOCHH_OP_ADDR_OUT: begin
          if (is_block) begin
            resp_d.cond_not_zero = 1'b0; // [RULE22]
            ld_xfer = !instr.word[`IOCHH_SEL_BIT]; // [RULE21]
            ld_param = instr.word[`IOCHH_SEL_BIT];
            bt_stop_d = bt_active; // [RULE23]
          end else if (is_unit_addr && idle && !other_unit) begin
            resp_d.cond_not_zero = 1'b0; // [RULE21] [RULE22]
            word_d = instr.acc;
            addr_valid_d = 1'b1;
            addr_sel_d = (cfg_kind == IOCHH_KIND_UNIT_X) ? req_unit[2:0] : {1'b0, req_unit[1:0]};
          end
        end
        default: begin
          resp_d.cond_not_zero = 1'b1;
        end
      endcase
    end
  end

  // Controller registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= IOCHH_ST_IDLE;
      sw_cnt_q <= 2'h0;
      conn_q <= 4'h0;
      target_q <= 4'h0;
      fwd_cmd_q <= 1'b0;
      fwd_data_q <= 1'b0;
      word_q <= 24'h000000;
      mode_q <= IOCHH_MODE_NORMAL;
      dead_q <= 1'b0;
      resp_q <= '0;
      bt_stop_q <= 1'b0;
      din_take_q <= 1'b0;
      addr_valid_q <= 1'b0;
      addr_sel_q <= 3'h0;
    end else begin
      state_q <= state_d;
      sw_cnt_q <= sw_cnt_d;
      conn_q <= conn_d;
      target_q <= target_d;
      fwd_cmd_q <= fwd_cmd_d;
      fwd_data_q <= fwd_data_d;
      word_q <= word_d;
      mode_q <= mode_d;
      dead_q <= dead_d;
      resp_q <= resp_d;
      bt_stop_q <= bt_stop_d;
      din_take_q <= din_take_d;
      addr_valid_q <= addr_valid_d;
      addr_sel_q <= addr_sel_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  wire wr_cfg = reg_wr && (reg_addr == `IOCHH_REG_CFG);
  wire wr_xfer = reg_wr && (reg_addr == `IOCHH_REG_XFER_ADDR);
  wire wr_param = reg_wr && (reg_addr == `IOCHH_REG_PARAM_ADDR);
  wire [23:0] status_word = {14'h0000, !idle, dead_q, mode_q, conn_q, bt_busy, !chan_drv_en};
  wire [23:0] rd_mux =
    (reg_addr == `IOCHH_REG_CFG) ? {16'h0000, cfg_q} :
    (reg_addr == `IOCHH_REG_STATUS) ? status_word :
    (reg_addr == `IOCHH_REG_XFER_ADDR) ? xfer_addr_q :
    (reg_addr == `IOCHH_REG_PARAM_ADDR) ? param_addr_q :
    (reg_addr == `IOCHH_REG_WORD_COUNT) ? bt_word_count : 24'h000000;

  // Address registers are untouched by a stop, so an interrupted transfer keeps them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q <= `IOCHH_CFG_RST;
      xfer_addr_q <= `IOCHH_ADDR_RST;
      param_addr_q <= `IOCHH_ADDR_RST;
      reg_rdata_q <= 24'h000000;
    end else begin
      if (wr_cfg) begin
        cfg_q <= reg_wdata[7:0];
      end
      if (ld_xfer) begin
        xfer_addr_q <= instr.acc; // [RULE21]
      end else if (wr_xfer) begin
        xfer_addr_q <= reg_wdata;
      end
      if (ld_param) begin
        param_addr_q <= instr.acc; // [RULE21]
      end else if (wr_param) begin
        param_addr_q <= reg_wdata;
      end
      reg_rdata_q <= reg_rd ? rd_mux : 24'h000000;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign resp = resp_q;
  assign reg_rdata = reg_rdata_q;
  assign unit_sel = conn_q;
  assign unit_link_up = (state_q != IOCHH_ST_SWITCH);
  assign unit_cmd_valid = (state_q == IOCHH_ST_CMD_PEND); // [RULE3] [RULE4]
  assign unit_dout_valid = (state_q == IOCHH_ST_DOUT_PEND); // [RULE14]
  assign unit_word = word_q;
  assign unit_din_take = din_take_q;
  assign unit_addr_valid = addr_valid_q;
  assign unit_addr_sel = addr_sel_q;
  assign chan_drv_en = (mode_q != IOCHH_MODE_OFFLINE); // [RULE26]
  assign chan_mpx_release = (mode_q == IOCHH_MODE_MPX) || (mode_q == IOCHH_MODE_OFFLINE);
  assign bt_stop = bt_stop_q; // [RULE6] [RULE23]

endmodule : iochh_handler
`default_nettype wire

// ---- hw/iochh_consts.svh ----
// Constants for the I/O channel instruction handler
// ----------------------------------------------------------------------------
// Summary of operation
// [RULE1] Command output takes an 8/24-bit accumulator command; zero when accepted.
// [RULE2] Instruction fields: unit 0-3, mode 4-5, channel 6-10, override 11, opcode 12-23.
// [RULE3] Override seizes channel, latches word, switches, answers zero, forwards.
// [RULE4] No override, other unit: not-zero, switch, forward.
// [RULE5] After a command the channel stays not ready until the unit takes it.
// [RULE6] Block transfer: override stops it, registers kept; else ignored.
// [RULE7] Status input returns unit status with zero; not-zero if unavailable.
// [RULE8] Status input refused while a command is pending at the unit.
// [RULE9] Status input to another unit: not-ready and start unit switch.
// [RULE10] Status during block transfer: zero, status bits 0-7, busy bit 23.
// [RULE11] Status input accepted while the unit still receives output data.
// [RULE12] Data output takes accumulator word with zero; not-zero when busy.
// [RULE13] Software right-justifies narrow output data; unit takes its own width.
// [RULE14] Data output to unconnected unit: zero, switch, deliver, then ready.
// [RULE15] Data output ignored with not-zero during a block transfer.
// [RULE16] Data input returns unit word with zero; refused while command executes.
// [RULE17] Data input to another unit: not-ready and start unit switch.
// [RULE18] Data input ignored with not-zero during a block transfer.
// [RULE19] Single-word mode, output command in progress: data input gets not-ready.
// [RULE20] Merge ORs input into accumulator, else clears it; right-aligned.
// [RULE21] Address output loads address/parameter register, or unit-addressed unit.
// [RULE22] Block channel always ready for address output; bad channel not ready.
// [RULE23] Address output never starts a transfer and terminates an active one.
// [RULE24] Condition starts not-zero each instruction; zero only when accepted.
// [RULE25] Disconnect/connect sequence takes two cycles.
// [RULE26] Mode bits: 00 normal, 01 multiplex, 10 offline, 11 back online.
// [RULE27] Non-existent channel or unit: accept, not-ready now and forever.
// [RULE28] Connected unit code is held and compared to each instruction's unit.
// ----------------------------------------------------------------------------
`ifndef IOCHH_CONSTS_SVH
`define IOCHH_CONSTS_SVH

// Instruction field positions
`define IOCHH_UNIT_LO 0
`define IOCHH_UNIT_HI 3
`define IOCHH_MODE_LO 4
`define IOCHH_MODE_HI 5
`define IOCHH_CHAN_LO 6
`define IOCHH_CHAN_HI 10
`define IOCHH_OVR_BIT 11
`define IOCHH_SEL_BIT 5

// Status word layout during a block transfer
`define IOCHH_ST_BUSY_BIT 23

// Disconnect/connect duration in cycles
`define IOCHH_SWITCH_CYCLES 2'h2

// Register offsets
`define IOCHH_REG_CFG 8'h00
`define IOCHH_REG_STATUS 8'h04
`define IOCHH_REG_XFER_ADDR 8'h08
`define IOCHH_REG_PARAM_ADDR 8'h0c
`define IOCHH_REG_WORD_COUNT 8'h10

// Reset values
`define IOCHH_CFG_RST 8'h00
`define IOCHH_ADDR_RST 24'h000000

`endif

// ---- hw/iochh_pkg.sv ----
// Types for the I/O channel instruction handler
`default_nettype none
package iochh_pkg;

  // Instruction kinds issued by the CPU
  typedef enum logic [2:0] {
    IOCHH_OP_CMD_OUT = 3'h0,
    IOCHH_OP_STAT_IN = 3'h1,
    IOCHH_OP_DATA_OUT = 3'h2,
    IOCHH_OP_DATA_IN = 3'h3,
    IOCHH_OP_ADDR_OUT = 3'h4
  } iochh_op_t;

  // Channel kinds
  typedef enum logic [1:0] {
    IOCHH_KIND_STD = 2'h0,
    IOCHH_KIND_BLOCK = 2'h1,
    IOCHH_KIND_UNIT_X = 2'h2,
    IOCHH_KIND_UNIT_I = 2'h3
  } iochh_kind_t;

  // Channel modes from the command mode field
  typedef enum logic [1:0] {
    IOCHH_MODE_NORMAL = 2'h0,
    IOCHH_MODE_MPX = 2'h1,
    IOCHH_MODE_OFFLINE = 2'h2,
    IOCHH_MODE_RESET = 2'h3
  } iochh_mode_t;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    IOCHH_ST_IDLE = 4'h1,
    IOCHH_ST_SWITCH = 4'h2,
    IOCHH_ST_CMD_PEND = 4'h4,
    IOCHH_ST_DOUT_PEND = 4'h8
  } iochh_state_t;

  // Instruction request from the CPU
  typedef struct packed {
    logic valid;
    iochh_op_t op;
    logic [23:0] word;
    logic [23:0] acc;
  } iochh_instr_t;

  // Answer to the CPU
  typedef struct packed {
    logic valid;
    logic cond_not_zero;
    logic acc_load;
    logic [23:0] acc;
  } iochh_resp_t;

endpackage : iochh_pkg
`default_nettype wire

// ---- tb/iochh_unit_model.sv ----
// Peripheral unit model on the far side of the channel
`default_nettype none
module iochh_unit_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic unit_cmd_valid,
  output logic unit_cmd_ready,
  input wire logic unit_dout_valid,
  output logic unit_dout_ready,
  output logic [7:0] unit_status,
  output logic unit_status_valid,
  output logic [23:0] unit_din,
  output logic unit_din_valid
);
  // Slow unit: a pending word is taken after a fixed wait
  parameter int DLY = 10;
  logic [7:0] cnt_q, cnt_d;

  // Wait counter runs while a command or data word is pending
  assign cnt_d = (!(unit_cmd_valid || unit_dout_valid) || cnt_q == DLY[7:0]) ? 8'h00 : cnt_q + 8'h01;
  always_ff @(posedge clk_sys) begin
    cnt_q <= rst_n ? cnt_d : 8'h00;
  end

  // Handshakes, status and input word
  assign unit_cmd_ready = unit_cmd_valid && cnt_q == DLY[7:0];
  assign unit_dout_ready = unit_dout_valid && cnt_q == DLY[7:0];
  assign unit_status = 8'h5a;
  assign unit_status_valid = 1'b1;
  assign unit_din = 24'h000a5c;
  assign unit_din_valid = 1'b1;
endmodule : iochh_unit_model
`default_nettype wire

// ---- tb/iochh_handler_checker.sv ----
// Port assertions for the instruction handler
`default_nettype none
module iochh_handler_checker import iochh_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire iochh_instr_t instr,
  input wire iochh_resp_t resp,
  input wire logic [3:0] unit_sel,
  input wire logic unit_link_up,
  input wire logic unit_cmd_valid,
  input wire logic unit_cmd_ready,
  input wire logic [23:0] unit_word,
  input wire logic unit_dout_valid,
  input wire logic unit_dout_ready,
  input wire logic unit_din_take,
  input wire logic bt_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Instruction decode
  wire logic is_stat = instr.valid && instr.op == IOCHH_OP_STAT_IN;
  wire logic is_din = instr.valid && instr.op == IOCHH_OP_DATA_IN;
  wire logic other_unit = instr.word[3:0] != unit_sel;
  // Link down for two cycles, then up
  sequence s_switch;
    !unit_link_up ##1 unit_link_up;
  endsequence
  sequence s_din_ok;
    is_din ##1 !resp.cond_not_zero;
  endsequence
  property p_answer; instr.valid |=> resp.valid; endproperty
  property p_quiet; !instr.valid |=> !resp.valid; endproperty
  property p_switch; $fell(unit_link_up) |=> s_switch; endproperty
  property p_cmd_hold; unit_cmd_valid && !unit_cmd_ready |=> unit_cmd_valid && $stable(unit_word); endproperty
  property p_dout_hold; unit_dout_valid && !unit_dout_ready |=> unit_dout_valid && $stable(unit_word); endproperty
  property p_stat_pend; is_stat && unit_cmd_valid && !bt_active |=> resp.cond_not_zero; endproperty
  property p_din_pend; is_din && unit_cmd_valid |=> resp.cond_not_zero; endproperty
  property p_other; (is_stat || is_din) && other_unit && !bt_active |=> resp.cond_not_zero; endproperty
  property p_take; s_din_ok |-> unit_din_take; endproperty
  property p_sel; unit_link_up && $past(unit_link_up) |-> $stable(unit_sel); endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_switch: assert property (p_switch) else $error("switch length");
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped");
  a_dout_hold: assert property (p_dout_hold) else $error("data dropped");
  a_stat_pend: assert property (p_stat_pend) else $error("status while pending");
  a_din_pend: assert property (p_din_pend) else $error("input while pending");
  a_other: assert property (p_other) else $error("other unit ready");
  a_take: assert property (p_take) else $error("input not taken");
  a_sel: assert property (p_sel) else $error("unit code moved");
endmodule : iochh_handler_checker

bind iochh_handler iochh_handler_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr), .resp(resp),
  .unit_sel(unit_sel), .unit_link_up(unit_link_up), .unit_cmd_valid(unit_cmd_valid),
  .unit_cmd_ready(unit_cmd_ready), .unit_word(unit_word), .unit_dout_valid(unit_dout_valid),
  .unit_dout_ready(unit_dout_ready), .unit_din_take(unit_din_take), .bt_active(bt_active));
`default_nettype wire

// ---- tb/iochh_handler_tb.sv ----
// Self-checking bench for the instruction handler
`include "iochh_consts.svh"
`default_nettype none
module iochh_handler_tb import iochh_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, reg_wr, reg_rd, bt_active;
  iochh_instr_t instr;
  iochh_resp_t resp;
  logic [7:0] reg_addr, unit_status;
  logic [23:0] reg_wdata, reg_rdata, unit_word, unit_din, bt_word_count, r_acc;
  logic [15:0] unit_present;
  logic [3:0] unit_sel;
  logic [2:0] unit_addr_sel;
  logic unit_link_up, unit_cmd_valid, unit_cmd_ready, unit_dout_valid, unit_dout_ready, unit_status_valid;
  logic unit_din_valid, unit_din_take, unit_addr_valid, chan_drv_en, chan_mpx_release, bt_stop, r_stop;
  int errors, num_checks, m;
  localparam iochh_op_t cmd_o = IOCHH_OP_CMD_OUT, st_i = IOCHH_OP_STAT_IN;
  localparam iochh_op_t dat_o = IOCHH_OP_DATA_OUT, dat_i = IOCHH_OP_DATA_IN;

  iochh_handler dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr), .resp(resp), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .unit_present(unit_present),
    .unit_sel(unit_sel), .unit_link_up(unit_link_up), .unit_cmd_valid(unit_cmd_valid), .unit_word(unit_word),
    .unit_cmd_ready(unit_cmd_ready), .unit_dout_valid(unit_dout_valid), .unit_dout_ready(unit_dout_ready),
    .unit_status(unit_status), .unit_status_valid(unit_status_valid), .unit_din(unit_din),
    .unit_din_valid(unit_din_valid), .unit_din_take(unit_din_take), .unit_addr_valid(unit_addr_valid),
    .unit_addr_sel(unit_addr_sel), .chan_drv_en(chan_drv_en), .chan_mpx_release(chan_mpx_release),
    .bt_active(bt_active), .bt_word_count(bt_word_count), .bt_stop(bt_stop));
  iochh_unit_model u_unit (.clk_sys(clk_sys), .rst_n(rst_n), .unit_cmd_valid(unit_cmd_valid),
    .unit_cmd_ready(unit_cmd_ready), .unit_dout_valid(unit_dout_valid), .unit_dout_ready(unit_dout_ready),
    .unit_status(unit_status), .unit_status_valid(unit_status_valid), .unit_din(unit_din),
    .unit_din_valid(unit_din_valid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock at 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  // Instruction word: unit, mode, channel, override or merge flag
  function automatic logic [23:0] wc(input logic [3:0] u, input logic f = 1'b0, input logic [1:0] md = 2'h0,
                                     input logic [4:0] ch = 5'h01);
    return {12'h000, f, ch, md, u};
  endfunction : wc

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic rw(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : rw

  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp, "read");
  endtask : rd

  // One instruction for one cycle, answer checked after it is withdrawn
  task automatic io(input iochh_op_t op, input logic [23:0] w, input logic nz, input logic [23:0] a = 24'h000000);
    @(posedge clk_sys);
    instr <= '{1'b1, op, w, a};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    @(negedge clk_sys);
    r_acc = resp.acc;
    r_stop = bt_stop;
    chk({22'h0, resp.valid, resp.cond_not_zero}, {22'h0, 1'b1, nz}, "cond");
  endtask : io

  // Bounded wait for a data offer or an idle unit side
  task automatic wait_unit(input logic dout);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (dout ? unit_dout_valid : (unit_link_up && !unit_cmd_valid && !unit_dout_valid)) break;
    end
    if (i == 60) begin
      errors++;
      $display("unexpected at %0t: unit side hung", $time);
      test_done();
    end
  endtask : wait_unit

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    num_checks = 0;
    instr = '0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    unit_present = 16'h0fff;
    bt_active = 1'b0;
    bt_word_count = 24'h000000;
    do_reset();
    rd(`IOCHH_REG_STATUS, 24'h000000);
    rd(`IOCHH_REG_XFER_ADDR, 24'h000000);
    rw(8'h14, 24'h123456);
    rd(8'h14, 24'h000000);
    rw(`IOCHH_REG_CFG, 24'h000001);
    rd(`IOCHH_REG_CFG, 24'h000001);
    $display("test registers done");
    io(st_i, wc(0, 0, 0, 2), 1'b1);
    io(st_i, wc(0), 1'b0);
    chk(r_acc, 24'h00005a, "status");
    io(cmd_o, wc(3), 1'b1, 24'h0000c4);
    io(st_i, wc(3), 1'b1);
    io(dat_i, wc(3), 1'b1);
    chk(unit_word, 24'h0000c4, "command");
    wait_unit(1'b0);
    chk({20'h0, unit_sel}, 24'h3, "unit");
    io(st_i, wc(3), 1'b0);
    io(cmd_o, wc(5, 1), 1'b0, 24'h00a1b2);
    wait_unit(1'b0);
    chk({20'h0, unit_sel}, 24'h5, "unit");
    io(st_i, wc(6), 1'b1);
    wait_unit(1'b0);
    io(st_i, wc(6), 1'b0);
    io(dat_i, wc(7), 1'b1);
    wait_unit(1'b0);
    io(dat_i, wc(7), 1'b0, 24'hff0000);
    chk(r_acc, 24'h000a5c, "cleared");
    io(dat_i, wc(7, 1), 1'b0, 24'hff0000);
    chk(r_acc, 24'hff0a5c, "merged");
    $display("test unit switching done");
    // Narrow character sent right-justified
    io(dat_o, wc(2), 1'b0, 24'h00007e);
    wait_unit(1'b1);
    io(st_i, wc(2), 1'b0);
    io(dat_o, wc(2), 1'b1, 24'h000011);
    chk(unit_word, 24'h00007e, "data");
    wait_unit(1'b0);
    // Mode table: multiplex, offline, back online
    for (m = 1; m < 4; m++) begin
      io(cmd_o, wc(2, 0, m[1:0]), 1'b0);
      wait_unit(1'b0);
      chk({22'h0, chan_drv_en, chan_mpx_release}, (m == 1) ? 24'h3 : (m == 2) ? 24'h1 : 24'h2, "mode");
    end
    $display("test data and modes done");
    rw(`IOCHH_REG_CFG, 24'h000021);
    bt_active <= 1'b1;
    bt_word_count <= 24'h000005;
    // Command, data output and data input all refused during a transfer
    for (m = 0; m < 4; m++) begin
      if (m != 1) io(iochh_op_t'(m[2:0]), wc(2), 1'b1, 24'h000001);
    end
    io(st_i, wc(2), 1'b0);
    chk(r_acc, 24'h80005a, "block status");
    io(IOCHH_OP_ADDR_OUT, wc(0), 1'b0, 24'h001234);
    chk({23'h0, r_stop}, 24'h1, "stop");
    rd(`IOCHH_REG_XFER_ADDR, 24'h001234);
    io(IOCHH_OP_ADDR_OUT, wc(0, 0, 0, 3), 1'b1, 24'h000001);
    io(cmd_o, wc(2, 1), 1'b0);
    chk({23'h0, r_stop}, 24'h1, "stop");
    bt_active <= 1'b0;
    wait_unit(1'b0);
    rw(`IOCHH_REG_CFG, 24'h0000a1);
    io(dat_o, wc(2), 1'b0);
    io(dat_i, wc(2), 1'b1);
    wait_unit(1'b0);
    rw(`IOCHH_REG_CFG, 24'h000041);
    io(IOCHH_OP_ADDR_OUT, wc(2), 1'b0, 24'h000777);
    chk({20'h0, unit_addr_valid, unit_addr_sel}, 24'h00000a, "unit address");
    $display("test block channel done");
    rw(`IOCHH_REG_CFG, 24'h000001);
    io(cmd_o, wc(12), 1'b1);
    io(st_i, wc(2), 1'b1);
    do_reset();
    io(st_i, wc(0, 0, 0, 0), 1'b0);
    $display("test dead unit and reset done");
    test_done();
  end
endmodule : iochh_handler_tb
`default_nettype wire
